// ### asnp_regs.svh
// Timing constants for the nibble memory controller
`ifndef ASNP_REGS_SVH
`define ASNP_REGS_SVH

`define ASNP_CLK_PERIOD_PS 5000
`define ASNP_READ_PERIOD_MIN_PS 10000
`define ASNP_INDEX_TO_VALID_DELAY_PS 10000
`define ASNP_DESELECT_TURN_OFF_DELAY_PS 5000
`define ASNP_STROBE_WIDTH_PS 7000
`define ASNP_WRITE_PERIOD_MIN_PS 10000
`define ASNP_SELECT_TO_WRITE_END_PS 7000
`define ASNP_DATA_SETUP_TO_WRITE_END_PS 5000
`define ASNP_UNGATE_TURN_OFF_DELAY_PS 5000

// Least times round up to whole cycles, at least one
`define ASNP_CYC_UP(t) \
	((((t) + `ASNP_CLK_PERIOD_PS - 1) / `ASNP_CLK_PERIOD_PS) < 1 ? 1 : \
	(((t) + `ASNP_CLK_PERIOD_PS - 1) / `ASNP_CLK_PERIOD_PS))

`define ASNP_READ_CYC `ASNP_CYC_UP(`ASNP_INDEX_TO_VALID_DELAY_PS)
`define ASNP_STROBE_CYC `ASNP_CYC_UP(`ASNP_STROBE_WIDTH_PS)
`define ASNP_TURN_CYC `ASNP_CYC_UP(`ASNP_UNGATE_TURN_OFF_DELAY_PS)
`define ASNP_IDX_W 20
`define ASNP_NIB_W 4

`endif

// ### asnp_pkg.sv
// Types shared by the nibble memory controller
`default_nettype none
package asnp_pkg;
	typedef struct packed {
		logic        write;
		logic [19:0] index;
		logic [3:0]  data;
	} asnp_req_type;

	typedef struct packed {
		logic        selectN;
		logic        strobeN;
		logic        gateN;
		logic [19:0] index;
		logic [3:0]  dataOut;
		logic        dataOe;
	} asnp_pins_type;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_READ  = 6'h02,
		ST_RDONE = 6'h04,
		ST_TURN  = 6'h08,
		ST_WRITE = 6'h10,
		ST_WEND  = 6'h20
	} asnp_state_type;
endpackage
`default_nettype wire

// ### asnp_wait_counter.sv
// Down counter that paces the read, strobe and turn-off phases of a memory cycle
`timescale 1ns/100ps
`default_nettype none
module asnp_wait_counter #(
	parameter int WIDTH = 4
) (
	// Clocking
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] loadValue,
	output logic                  done
);
	logic [WIDTH-1:0] count_q;

	// A zero-width counter cannot pace anything
	if (WIDTH < 1) begin : g_badWidth
		$error("asnp_wait_counter: WIDTH must be at least 1");
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			count_q <= '0;
		end else if (clkEn) begin
			if (load) begin
				count_q <= loadValue;
			end else if (count_q != '0) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	assign done = (count_q == '0) && !load;
endmodule
`default_nettype wire

// ### asnp_controller.sv
// Host controller for the asynchronous one-megaword nibble memory
`timescale 1ns/100ps
`default_nettype none
`include "asnp_regs.svh"

// How it works
// (R01) Select, strobe and gate drive the memory into exactly one mode.
// (R02) Read strobes read data only after the full read period.
// (R03) Read is select-timed, data sampled after the access delay.
// (R04) Gate goes low together with select; access delay covers it.
// (R05) Index held stable until read data is captured.
// (R06) Memory turn-on is harmless since host stops driving before reading.
// (R07) After a read, host waits turn-off delay before driving data.
// (R08) Only one memory part; deselect precedes any other driver.
// (R09) Write ends by strobe rising while select stays low.
// (R10) Strobe held low at least its minimum width with gate high.
// (R11) Select and index valid well before write end; cycle long enough.
// (R12) Index set on the edge where strobe falls and held past strobe rising.
// (R13) Write data driven from cycle start until after write end.
// (R14) Host drives data only while strobe is low or gate high.
// (R15) Select falls with strobe, so memory outputs stay floating.
// (R16) Host never drives data while memory is in read mode.
// (R17) Every read presents the index first, then samples new contents.
// (R18) Index set on the same edge that select falls for reads.
// (R19) Twenty index lines and four shared data pins.
// (R20) No refresh or clock activity is ever sent to the memory.
// (R21) Gate stays high whenever host drives write data.
module asnp_controller #(
	parameter int IDX_W = `ASNP_IDX_W,
	parameter int NIB_W = `ASNP_NIB_W
) (
	// Clocking
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 clkEn,
	// User request
	input  wire logic                 reqValid,
	output logic                      reqReady,
	input  wire asnp_pkg::asnp_req_type req,
	// User answer
	output logic                      rspValid,
	output logic [NIB_W-1:0]          rspData,
	// Memory pins
	output logic                      selectN,
	output logic                      strobeN,
	output logic                      gateN,
	output logic [IDX_W-1:0]          wordIndexLines,
	output logic [NIB_W-1:0]          sharedNibblePinsOut,
	output logic                      sharedNibblePinsOe,
	input  wire logic [NIB_W-1:0]     sharedNibblePinsIn
);
	localparam int CW = 4;
	localparam logic [CW-1:0] READ_CYC   = CW'(`ASNP_READ_CYC);
	localparam logic [CW-1:0] STROBE_CYC = CW'(`ASNP_STROBE_CYC);
	localparam logic [CW-1:0] TURN_CYC   = CW'(`ASNP_TURN_CYC);

	// (R19) width check
	if (IDX_W != `ASNP_IDX_W || NIB_W != `ASNP_NIB_W) begin : g_badWidth
		$error("asnp_controller: widths fixed by the memory");
	end
	// (R11) counts fit counter
	if (`ASNP_READ_CYC >= (1 << CW) || `ASNP_STROBE_CYC >= (1 << CW) ||
		`ASNP_TURN_CYC >= (1 << CW)) begin : g_badCount
		$error("asnp_controller: wait counts exceed the counter");
	end

	typedef struct packed {
		asnp_pkg::asnp_state_type state;
		asnp_pkg::asnp_pins_type  pins;
		logic                     rspValid;
		logic [3:0]               rspData;
	} asnp_ctl_type;

	asnp_ctl_type s_q;
	asnp_ctl_type s_d;
	logic         load;
	logic [CW-1:0] loadValue;
	logic         waitDone;

	asnp_wait_counter #(.WIDTH(CW)) u_wait (
		.mclk      (mclk),
		.rst       (rst),
		.clkEn     (clkEn),
		.load      (load),
		.loadValue (loadValue),
		.done      (waitDone)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		load = 1'b0;
		loadValue = '0;
		s_d.rspValid = 1'b0;
		case (s_q.state)
			asnp_pkg::ST_IDLE: begin
				if (reqValid) begin
					// (R12) (R18) index set with select
					s_d.pins.index = req.index;
					load = 1'b1;
					if (req.write) begin
						// (R11) select and index lead write end
						// (R15) select with strobe; (R21) gate high
						s_d.pins.selectN = 1'b0;
						s_d.pins.strobeN = 1'b0;
						s_d.pins.gateN = 1'b1;
						s_d.pins.dataOut = req.data;
						s_d.pins.dataOe = 1'b1;
						loadValue = STROBE_CYC;
						s_d.state = asnp_pkg::ST_WRITE;
					end else begin
						// (R03) select-timed read
						s_d.pins.selectN = 1'b0;
						s_d.pins.gateN = 1'b0;
						// (R16) host lets go of data pins
						s_d.pins.dataOe = 1'b0;
						loadValue = READ_CYC;
						s_d.state = asnp_pkg::ST_READ;
					end
				end
			end
			asnp_pkg::ST_READ: begin
				// (R02) sample after full access time
				if (waitDone) begin
					s_d.rspData = sharedNibblePinsIn;
					s_d.rspValid = 1'b1;
					s_d.state = asnp_pkg::ST_RDONE;
				end
			end
			asnp_pkg::ST_RDONE: begin
				// (R07) release, then wait memory turn-off
				s_d.pins.selectN = 1'b1;
				s_d.pins.gateN = 1'b1;
				load = 1'b1;
				loadValue = TURN_CYC;
				s_d.state = asnp_pkg::ST_TURN;
			end
			asnp_pkg::ST_TURN: begin
				if (waitDone)
					s_d.state = asnp_pkg::ST_IDLE;
			end
			asnp_pkg::ST_WRITE: begin
				// (R10) strobe width then (R09) strobe ends write
				if (waitDone) begin
					s_d.pins.strobeN = 1'b1;
					s_d.state = asnp_pkg::ST_WEND;
				end
			end
			asnp_pkg::ST_WEND: begin
				// (R13) data held one cycle past write end
				s_d.pins.selectN = 1'b1;
				s_d.pins.dataOe = 1'b0;
				s_d.state = asnp_pkg::ST_IDLE;
			end
			default: begin
				s_d.state = asnp_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q.state <= asnp_pkg::ST_IDLE;
			s_q.pins <= '{selectN: 1'b1, strobeN: 1'b1, gateN: 1'b1,
				index: '0, dataOut: '0, dataOe: 1'b0};
			s_q.rspValid <= 1'b0;
			s_q.rspData <= '0;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	assign reqReady = (s_q.state == asnp_pkg::ST_IDLE) && clkEn;
	assign rspValid = s_q.rspValid;
	assign rspData = s_q.rspData;
	assign selectN = s_q.pins.selectN;
	assign strobeN = s_q.pins.strobeN;
	assign gateN = s_q.pins.gateN;
	assign wordIndexLines = s_q.pins.index;
	assign sharedNibblePinsOut = s_q.pins.dataOut;
	assign sharedNibblePinsOe = s_q.pins.dataOe;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_strobeFall;
		$fell(strobeN);
	endsequence

	property p_noContention;
		@(posedge mclk) disable iff (rst)
		sharedNibblePinsOe |-> (gateN || !strobeN || selectN);
	endproperty
	a_noContention: assert property (p_noContention) // (R16)
		else $error("host drives data while memory reads");

	property p_gateHighOnWrite;
		@(posedge mclk) disable iff (rst)
		!strobeN |-> gateN && sharedNibblePinsOe;
	endproperty
	a_gateHighOnWrite: assert property (p_gateHighOnWrite) // (R21)
		else $error("gate low during write");

	property p_strobeWidth;
		@(posedge mclk) disable iff (rst || !clkEn)
		s_strobeFall |-> !strobeN [*2];
	endproperty
	a_strobeWidth: assert property (p_strobeWidth) // (R10)
		else $error("write strobe too short");

	property p_indexHeldWrite;
		@(posedge mclk) disable iff (rst)
		!strobeN |=> $stable(wordIndexLines);
	endproperty
	a_indexHeldWrite: assert property (p_indexHeldWrite) // (R12)
		else $error("index moved during write");

	property p_dataHold;
		@(posedge mclk) disable iff (rst)
		$rose(strobeN) |-> sharedNibblePinsOe && !selectN;
	endproperty
	a_dataHold: assert property (p_dataHold) // (R13)
		else $error("write data dropped at write end");

	property p_selectWithStrobe;
		@(posedge mclk) disable iff (rst)
		$fell(selectN) && !sharedNibblePinsOe |-> strobeN;
	endproperty
	a_selectWithStrobe: assert property (p_selectWithStrobe) // (R15)
		else $error("read select with strobe low");

	property p_readIndexStable;
		@(posedge mclk) disable iff (rst)
		!selectN && !gateN |=> $stable(wordIndexLines);
	endproperty
	a_readIndexStable: assert property (p_readIndexStable) // (R05)
		else $error("index moved during read");

	property p_readPeriod;
		@(posedge mclk) disable iff (rst || !clkEn)
		$fell(gateN) |-> !rspValid [*2];
	endproperty
	a_readPeriod: assert property (p_readPeriod) // (R02)
		else $error("read answered too early");

	property p_turnaround;
		@(posedge mclk) disable iff (rst || !clkEn)
		$rose(gateN) |-> !sharedNibblePinsOe [*2];
	endproperty
	a_turnaround: assert property (p_turnaround) // (R07)
		else $error("host drives before memory turned off");
endmodule
`default_nettype wire

// ### asnp_sram_model.sv
// Behavioural model of the one-megaword nibble memory
`timescale 1ns/100ps
`default_nettype none
module asnp_sram_model (
	// Memory pins
	input  wire logic        selectN,
	input  wire logic        strobeN,
	input  wire logic        gateN,
	input  wire logic [19:0] index,
	input  wire logic [3:0]  hostData,
	input  wire logic        hostOe,
	// Seen by the host
	output logic [3:0]       pins,
	output logic             clash
);
	// ----
	// Store and decode
	// ----
	// static word store
	logic [3:0] mem [logic [19:0]];
	logic [3:0] word;
	logic       writing;
	logic       reading;
	initial pins = 4'h5;
	assign writing = !selectN && !strobeN;
	assign reading = !selectN && strobeN && !gateN;
	assign clash   = hostOe && reading;
	// capture at write end; start-up edge ignored
	always @(negedge writing) begin
		if (^index !== 1'bx && hostOe === 1'b1)
			mem[index] = hostData;
	end
	// release beats any turn-on, shows inverse
	always @(reading or index) begin
		word = mem.exists(index) ? mem[index] : ~index[3:0];
		if (reading) begin
			pins <= #3 ~word;
			pins <= #10 word;
		end else begin
			pins <= #2 ~pins;
		end
	end
endmodule
`default_nettype wire

// ### test_async_sram_nibble_port.sv
// Self-checking bench for the nibble memory controller
`timescale 1ns/100ps
`default_nettype none
module test_async_sram_nibble_port;
	logic                   mclk = 1'b0;
	logic                   rst = 1'b1;
	logic                   clkEn = 1'b1;
	logic                   reqValid = 1'b0;
	asnp_pkg::asnp_req_type req = '0;
	logic                   reqReady, rspValid, selectN, strobeN, gateN;
	logic                   pinsOe, clash;
	logic [3:0]             rspData, pinsOut, memPins, lowRun = 4'h0;
	logic [3:0]             wireLvl;
	logic [19:0]            idx, lastIdx;
	logic                   lastSel = 1'b1;
	int                     n_fail = 0;
	int                     total_checks = 0;

	always #2.5 mclk = ~mclk;
	assign wireLvl = pinsOe ? pinsOut : memPins;

	asnp_controller dut (.mclk(mclk), .rst(rst), .clkEn(clkEn),
		.reqValid(reqValid), .reqReady(reqReady), .req(req),
		.rspValid(rspValid), .rspData(rspData), .selectN(selectN),
		.strobeN(strobeN), .gateN(gateN), .wordIndexLines(idx),
		.sharedNibblePinsOut(pinsOut), .sharedNibblePinsOe(pinsOe),
		.sharedNibblePinsIn(wireLvl));
	asnp_sram_model model (.selectN(selectN), .strobeN(strobeN),
		.gateN(gateN), .index(idx), .hostData(pinsOut), .hostOe(pinsOe),
		.pins(memPins), .clash(clash));

	// ----
	// Shared tasks
	// ----
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic bail();
		n_fail++;
		$display("CHECK FAILED at %0t: no answer in time", $time);
		finish_test();
	endtask

	task automatic send(input logic wr, input logic [19:0] i_,
		input logic [3:0] d);
		int i;
		reqValid = 1'b1;
		req = '{write: wr, index: i_, data: d};
		for (i = 0; i < 20 && reqReady !== 1'b1; i++)
			@(negedge mclk);
		if (i == 20)
			bail();
		@(negedge mclk);
		reqValid = 1'b0;
		// Busy engine refuses more work
		check(reqReady, 1'b0);
		// One idle edge keeps valid low between requests
		@(negedge mclk);
	endtask

	task automatic read_back(input logic [19:0] i_, input logic [3:0] exp);
		int i;
		send(1'b0, i_, 4'h0);
		for (i = 0; i < 10 && rspValid !== 1'b1; i++)
			@(negedge mclk);
		if (i == 10)
			bail();
		check(rspData, exp);
	endtask

	// ----
	// Pin monitor
	// ----
	always @(negedge mclk) begin
		if (rst === 1'b0) begin
			check({clash, pinsOe & ~gateN}, 2'b00);
			if (strobeN === 1'b0)
				check({selectN, gateN, pinsOe}, 3'b011);
			if (lastSel === 1'b0 && selectN === 1'b0)
				check(idx, lastIdx);
			if (strobeN === 1'b0)
				lowRun = lowRun + 4'h1;
			else if (lowRun != 4'h0) begin
				check(lowRun >= 4'h2, 1'b1);
				lowRun = 4'h0;
			end
		end else begin
			// A write cut by reset is not a short strobe
			lowRun = 4'h0;
		end
		lastSel = selectN;
		lastIdx = idx;
	end

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		rst = 1'b1;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		check({selectN, strobeN, gateN, pinsOe, rspValid}, 5'b11100);
	endtask

	task automatic t_boundary();
		send(1'b1, 20'h00000, 4'hc);
		send(1'b1, 20'hfffff, 4'h5);
		read_back(20'h00000, 4'hc);
		read_back(20'hfffff, 4'h5);
	endtask

	task automatic t_overwrite();
		send(1'b1, 20'h0f0f0, 4'h1);
		send(1'b1, 20'h0f0f0, 4'h7);
		read_back(20'h0f0f0, 4'h7);
	endtask

	task automatic t_freeze();
		int i;
		// Freeze only once the engine is idle and deselected
		for (i = 0; i < 20 && reqReady !== 1'b1; i++)
			@(negedge mclk);
		if (i == 20)
			bail();
		clkEn = 1'b0;
		reqValid = 1'b1;
		req = '{write: 1'b1, index: 20'h00001, data: 4'h9};
		repeat (3) begin
			@(negedge mclk);
			check({reqReady, selectN}, 2'b01);
		end
		// Held request becomes a read as the clock returns
		clkEn = 1'b1;
		read_back(20'h00001, 4'he);
	endtask

	task automatic t_mid_reset();
		// Reset cuts a write in flight
		send(1'b1, 20'h0abcd, 4'h3);
		t_reset();
		read_back(20'h12345, 4'ha);
	endtask

	initial begin
		t_reset();
		t_boundary();
		t_overwrite();
		t_freeze();
		t_mid_reset();
		finish_test();
	end
endmodule
`default_nettype wire
